// ### rtl/buzzer_pkg.sv
// constants, field layout and timing for the buzzer tone generator
//
// Overview of operation
// - every tone is divided down from the 32.768 kHz oscillator; eight selectable tones
// - select codes 000..111 give 4096.0 down to 1170.3 Hz
// - optional envelope steps duty through eight levels, maximum down to minimum
// - inverted tone output is the logical inverse of the tone output while sounding; both are low while off
// - envelope applies only while enabled; otherwise duty stays at maximum
// - writing 1 to envelope restart while enabled returns duty to maximum
// - envelope steps every 62.5 ms with rate bit 0, 125 ms with 1
// - first envelope step may come up to 4 ms early; later steps exact
// - periods 16/20/24/28 phase steps (one sub-period each, two in the lower octave), high counts 8/8/12/12 minus level
// - burst lasts 31.25 ms with length bit 0, 62.5 ms with 1
// - after a trigger write the burst starts at the next 256 Hz edge
// - burst stops automatically after its length, aligned to 256 Hz
// - trigger bit reads 1 from trigger until output off, else 0
// - inverted output exists only when the tone output option is also built
// - tone control bit 1 drives outputs low except while a one-shot burst rings; 0 outputs the tone
// - trigger accepted only while regular tone is off; ignored otherwise
package buzzer_pkg;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_PORT_CTRL = 14'h0f54;
  localparam logic [13:0] IDX_FREQ_LEN = 14'h0f74;
  localparam logic [13:0] IDX_ENV_SHOT = 14'h0f75;

  localparam logic [3:0] PORT_CTRL_RST = 4'hf;
  localparam logic [3:0] FREQ_LEN_RST = 4'h0;
  localparam logic [3:0] ENV_SHOT_RST = 4'h0;

  localparam int BIT_TONE_CTRL = 3;
  localparam int BIT_INV_CTRL = 2;
  localparam int BIT_BURST_LEN = 3;
  localparam int FREQ_LSB = 0;
  localparam int FREQ_W = 3;
  localparam int BIT_ENV_EN = 0;
  localparam int BIT_ENV_RATE = 1;
  localparam int BIT_ENV_RESTART = 2;
  localparam int BIT_BURST = 3;

  // sub-period ticks come from both oscillator edges, 65536 Hz
  localparam int SUB_HZ = 65_536;
  localparam int TICK_HZ = 256;
  localparam int SUB_PER_TICK = SUB_HZ / TICK_HZ;

  localparam int ENV_FAST_US = 62_500;
  localparam int ENV_SLOW_US = 125_000;
  localparam int BURST_SHORT_US = 31_250;
  localparam int BURST_LONG_US = 62_500;
  localparam int ENV_FAST_TICKS = ENV_FAST_US * TICK_HZ / 1_000_000;
  localparam int ENV_SLOW_TICKS = ENV_SLOW_US * TICK_HZ / 1_000_000;
  localparam int BURST_SHORT_TICKS = BURST_SHORT_US * TICK_HZ / 1_000_000;
  localparam int BURST_LONG_TICKS = BURST_LONG_US * TICK_HZ / 1_000_000;

  localparam int PERIOD_BASE = 16;
  localparam int PERIOD_STEP = 4;
  localparam int HIGH_SHORT = 8;
  localparam int HIGH_LONG = 12;
  localparam logic [2:0] LEVEL_MIN = 3'h7;

  typedef enum logic [1:0] {BURST_IDLE, BURST_WAIT, BURST_RING} burst_state_e;

endpackage

// ### rtl/buzzer_tone_generator.sv
// buzzer tone generator with envelope, one-shot burst and apb registers
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module buzzer_tone_generator
  import buzzer_pkg::*;
#(
  parameter bit TONE_OUT_OPT = 1'b1,
  parameter bit INV_OUT_OPT = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_32k_in,
  output logic tone_out,
  output logic tone_out_inverted
);

  // inverted pin only exists when the tone pin option is built
  localparam bit INV_EFF = TONE_OUT_OPT && INV_OUT_OPT;

  // oscillator synchroniser; stage one feeds only stage two
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic sub_tick;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else
    begin
      osc_s1_q <= osc_32k_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // both oscillator edges give the 65536 Hz sub-period
  assign sub_tick = osc_s2_q ^ osc_s3_q;

  // apb slave and registers
  logic [3:0] port_ctrl_q, port_ctrl_d;
  logic [3:0] freq_len_q, freq_len_d;
  logic env_en_q, env_en_d, env_rate_q, env_rate_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic sel_port, sel_freq, sel_env, wr_done, trig_wr, restart_wr;
  logic burst_busy;

  assign sel_port = (paddr[15:2] == IDX_PORT_CTRL) && (paddr[1:0] == 2'h0);
  assign sel_freq = (paddr[15:2] == IDX_FREQ_LEN) && (paddr[1:0] == 2'h0);
  assign sel_env = (paddr[15:2] == IDX_ENV_SHOT) && (paddr[1:0] == 2'h0);
  // writes land on the edge that samples pready high
  assign wr_done = psel && penable && pready_q && pwrite;
  assign trig_wr = wr_done && sel_env && pwdata[BIT_BURST];
  assign restart_wr = wr_done && sel_env && pwdata[BIT_ENV_RESTART];

  always_comb
  begin
    port_ctrl_d = port_ctrl_q;
    freq_len_d = freq_len_q;
    env_en_d = env_en_q;
    env_rate_d = env_rate_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    pready_d = psel && penable && !pready_q;
    if (psel && penable && !pready_q)
    begin
      pslverr_d = !(sel_port || sel_freq || sel_env);
      prdata_d = 32'h0000_0000;
      if (!pwrite)
      begin
        if (sel_port)
          prdata_d[3:0] = port_ctrl_q;
        else if (sel_freq)
          prdata_d[3:0] = freq_len_q;
        else if (sel_env)
          prdata_d[3:0] = {burst_busy, 1'b0, env_rate_q, env_en_q};
      end
    end
    if (wr_done && sel_port)
      port_ctrl_d = pwdata[3:0];
    if (wr_done && sel_freq)
      freq_len_d = pwdata[3:0];
    if (wr_done && sel_env)
    begin
      env_en_d = pwdata[BIT_ENV_EN];
      env_rate_d = pwdata[BIT_ENV_RATE];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_ctrl_q <= PORT_CTRL_RST;
      freq_len_q <= FREQ_LEN_RST;
      env_en_q <= ENV_SHOT_RST[BIT_ENV_EN];
      env_rate_q <= ENV_SHOT_RST[BIT_ENV_RATE];
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      port_ctrl_q <= port_ctrl_d;
      freq_len_q <= freq_len_d;
      env_en_q <= env_en_d;
      env_rate_q <= env_rate_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // 256 hz timebase from the sub-period ticks
  logic [7:0] pre_q, pre_d;
  logic half_q, half_d;
  logic tick256, tone_step;

  assign tick256 = sub_tick && (pre_q == 8'(SUB_PER_TICK - 1));
  // lower octave advances on every other sub-period
  assign tone_step = sub_tick && (!freq_len_q[FREQ_LSB + 2] || half_q);

  always_comb
  begin
    pre_d = pre_q;
    half_d = half_q;
    if (sub_tick)
    begin
      pre_d = pre_q + 8'h01;
      half_d = !half_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q <= 8'h00;
      half_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      half_q <= half_d;
    end
  end

  // one-shot burst
  burst_state_e burst_q, burst_d;
  logic [4:0] burst_cnt_q, burst_cnt_d;
  logic [4:0] burst_len;

  assign burst_len = freq_len_q[BIT_BURST_LEN] ? 5'(BURST_LONG_TICKS) : 5'(BURST_SHORT_TICKS);
  assign burst_busy = (burst_q != BURST_IDLE);

  always_comb
  begin
    burst_d = burst_q;
    burst_cnt_d = burst_cnt_q;
    case (burst_q)
      BURST_IDLE:
      begin
        // regular tone on means control bit 0; trigger is dropped then
        if (trig_wr && port_ctrl_q[BIT_TONE_CTRL])
          burst_d = BURST_WAIT;
      end
      BURST_WAIT:
      begin
        if (tick256)
        begin
          burst_d = BURST_RING;
          burst_cnt_d = 5'h00;
        end
      end
      BURST_RING:
      begin
        if (tick256)
        begin
          if (burst_cnt_q >= burst_len - 5'h01)
            burst_d = BURST_IDLE;
          else
            burst_cnt_d = burst_cnt_q + 5'h01;
        end
      end
      default:
        burst_d = BURST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      burst_q <= BURST_IDLE;
      burst_cnt_q <= 5'h00;
    end
    else
    begin
      burst_q <= burst_d;
      burst_cnt_q <= burst_cnt_d;
    end
  end

  // envelope; counter restarts on enable so the first step comes under one 256 hz tick early
  logic sounding;
  logic [2:0] level_q, level_d;
  logic [5:0] env_cnt_q, env_cnt_d;
  logic [5:0] env_steps;

  assign sounding = !port_ctrl_q[BIT_TONE_CTRL] || (burst_q == BURST_RING);
  assign env_steps = env_rate_q ? 6'(ENV_SLOW_TICKS) : 6'(ENV_FAST_TICKS);

  always_comb
  begin
    level_d = level_q;
    env_cnt_d = env_cnt_q;
    if (!env_en_q || !sounding || restart_wr)
    begin
      level_d = 3'h0;
      env_cnt_d = 6'h00;
    end
    else if (tick256)
    begin
      if (env_cnt_q >= env_steps - 6'h01)
      begin
        env_cnt_d = 6'h00;
        if (level_q != LEVEL_MIN)
          level_d = level_q + 3'h1;
      end
      else
        env_cnt_d = env_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_q <= 3'h0;
      env_cnt_q <= 6'h00;
    end
    else
    begin
      level_q <= level_d;
      env_cnt_q <= env_cnt_d;
    end
  end

  // tone waveform; changing the select mid-tone can glitch one period
  logic [4:0] ph_q, ph_d;
  logic [4:0] period, high_cnt;
  logic tone_q, tone_d, inv_q, inv_d, act_q;

  assign period = 5'(PERIOD_BASE) + {freq_len_q[FREQ_LSB + 1:FREQ_LSB], 2'b00};
  assign high_cnt = (freq_len_q[FREQ_LSB + 1] ? 5'(HIGH_LONG) : 5'(HIGH_SHORT)) - {2'b00, level_q};

  always_comb
  begin
    ph_d = ph_q;
    if (!sounding)
      ph_d = 5'h00;
    else if (tone_step)
      ph_d = (ph_q >= period - 5'h01) ? 5'h00 : ph_q + 5'h01;
    tone_d = port_ctrl_q[BIT_TONE_CTRL];
    inv_d = port_ctrl_q[BIT_INV_CTRL];
    if (TONE_OUT_OPT)
      tone_d = sounding && (ph_q < high_cnt);
    if (INV_EFF)
      inv_d = sounding && !(ph_q < high_cnt);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_q <= 5'h00;
      tone_q <= 1'b0;
      inv_q <= 1'b0;
      act_q <= 1'b0;
    end
    else
    begin
      ph_q <= ph_d;
      tone_q <= tone_d;
      inv_q <= inv_d;
      act_q <= sounding;
    end
  end

  assign tone_out = tone_q;
  assign tone_out_inverted = inv_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_inv_complement: assert property (INV_EFF && act_q |-> tone_out_inverted == !tone_out)
    else $error("inverted output not complement of tone");
  a_off_outputs_low: assert property (TONE_OUT_OPT && !act_q |-> !tone_out && (!INV_EFF || !tone_out_inverted))
    else $error("outputs not low while tone off");
  a_trig_ignored: assert property (trig_wr && !port_ctrl_q[BIT_TONE_CTRL] && burst_q == BURST_IDLE
    |=> burst_q == BURST_IDLE)
    else $error("trigger accepted while regular tone on");
  a_trig_busy: assert property (trig_wr && port_ctrl_q[BIT_TONE_CTRL] |=> burst_busy)
    else $error("busy not set after trigger");
  a_burst_start: assert property (burst_q == BURST_WAIT && tick256 |=> burst_q == BURST_RING ##0 act_q == 1'b0
    ##1 act_q)
    else $error("burst did not start on 256 hz tick");
  a_burst_stop: assert property ($fell(burst_q == BURST_RING) |-> $past(tick256)
    && $past(burst_cnt_q) == burst_len - 5'h01)
    else $error("burst ended off tick or at wrong length");
  a_env_off_max: assert property (!env_en_q |=> level_q == 3'h0)
    else $error("duty not at maximum with envelope off");
  a_env_restart: assert property (restart_wr && env_en_q |=> level_q == 3'h0 && env_cnt_q == 6'h00)
    else $error("envelope restart ignored");
  a_env_step: assert property ($changed(level_q) && level_q != 3'h0 |-> $past(tick256)
    && $past(env_cnt_q) == env_steps - 6'h01)
    else $error("envelope stepped at wrong time");
  a_phase_range: assert property (ph_q < period)
    else $error("tone phase beyond period");
  a_apb_answer: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer not one cycle");

  c_burst_done: cover property (burst_q == BURST_RING ##1 burst_q == BURST_IDLE);
  c_env_floor: cover property (level_q == LEVEL_MIN && sounding);
  c_bad_addr: cover property (pready_q && pslverr_q);
  c_restart: cover property (restart_wr && env_en_q && level_q != 3'h0);

endmodule
`default_nettype wire

// ### testbench/buzzer_model.sv
// piezo buzzer model that measures period and high time on the tone pin and high time on the inverted pin
`timescale 1ns/100ps
`default_nettype none
module buzzer_model
(
  input wire logic clk,
  input wire logic tone_out,
  input wire logic tone_out_inverted,
  output logic [15:0] period_len,
  output logic [15:0] high_len,
  output logic [15:0] inv_len
);
  logic [15:0] cnt = 16'h0000;
  logic [15:0] hcnt = 16'h0000;
  logic [15:0] icnt = 16'h0000;
  logic last = 1'b0;
  // passive load: it only listens, so nothing is driven back
  always @(posedge clk)
  begin
    last <= tone_out;
    if (tone_out && !last)
    begin
      period_len <= cnt;
      high_len <= hcnt;
      inv_len <= icnt;
      cnt <= 16'h0001;
      hcnt <= 16'h0001;
      icnt <= 16'h0000;
    end
    else
    begin
      cnt <= cnt + 16'h0001;
      hcnt <= hcnt + 16'(tone_out);
      icnt <= icnt + 16'(tone_out_inverted);
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_buzzer_tone_generator.sv
// self-checking bench for the buzzer tone generator
`timescale 1ns/100ps
`default_nettype none
module tb_buzzer_tone_generator;
  import buzzer_pkg::*;
  localparam logic [15:0] A_PORT = {IDX_PORT_CTRL, 2'b00};
  localparam logic [15:0] A_FREQ = {IDX_FREQ_LEN, 2'b00};
  localparam logic [15:0] A_ENV = {IDX_ENV_SHOT, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic osc = 1'b0;
  logic [1:0] div = 2'b00;
  logic [31:0] prdata;
  logic pready, pslverr, tone, tone_n;
  logic [15:0] per, hi, inv;
  logic [33:0] expq[$];
  logic [33:0] e;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  integer seed = 64;
  buzzer_tone_generator u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_32k_in(osc), .tone_out(tone), .tone_out_inverted(tone_n));
  buzzer_model u_buzz (.clk(pclk), .tone_out(tone), .tone_out_inverted(tone_n), .period_len(per),
    .high_len(hi), .inv_len(inv));
  always #5 pclk = ~pclk;
  // oscillator sped up to one edge per 4 pclk so the run stays short
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    div <= div + 2'b01;
    if (div == 2'b11)
      osc <= ~osc;
    if (cyc == 99000)
    begin
      err_total++;
      summarize();
    end
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // answer taken at the rising edge that samples pready high
  always @(posedge pclk)
    if (pready === 1'b1)
    begin
      if (expq.size() == 0)
      begin
        err_total++;
        $display("mismatch apb answer expected none seen one");
      end
      else
      begin
        e = expq.pop_front();
        check("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
        if (e[33])
          check("prdata", e[31:0], prdata);
      end
    end
  task automatic apb(logic wr, logic [15:0] a, logic [31:0] d, logic [33:0] ex);
    @(posedge pclk);
    expq.push_back(ex);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the bench timeout ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] d);
    apb(1'b1, a, d, {2'b00, 32'h0000_0000});
  endtask
  task automatic rd(logic [15:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, {2'b10, x});
  endtask
  task automatic tone_chk(logic [2:0] sel);
    int sub;
    logic [2:0] r;
    sub = sel[2] ? 8 : 4;
    r = 3'($random(seed));
    wr(A_PORT, 32'h0000_000f);
    wr(A_FREQ, {29'h0, sel});
    wr(A_PORT, {29'h0, r});
    rd(A_PORT, {29'h0, r});
    repeat (500) @(posedge pclk);
    check("period", (16 + 4 * sel[1:0]) * sub, {16'h0, per});
    check("high", (sel[1] ? 12 : 8) * sub, {16'h0, hi});
    check("inverse", {16'h0, per - hi}, {16'h0, inv});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_PORT, 32'h0000_000f);
    rd(A_FREQ, 32'h0000_0000);
    rd(A_ENV, 32'h0000_0000);
    apb(1'b0, 16'h3d54, 32'h0000_0000, {2'b11, 32'h0000_0000});
    for (int s = 7; s >= 0; s--)
      tone_chk(3'(s));
    wr(A_ENV, 32'h0000_0001);
    repeat (17600) @(posedge pclk);
    check("env step", 28, {16'h0, hi});
    wr(A_ENV, 32'h0000_0000);
    repeat (500) @(posedge pclk);
    check("env off", 32, {16'h0, hi});
    wr(A_ENV, 32'h0000_0001);
    repeat (17600) @(posedge pclk);
    wr(A_ENV, 32'h0000_0007);
    repeat (17600) @(posedge pclk);
    check("env restart", 32, {16'h0, hi});
    wr(A_ENV, 32'h0000_0000);
    wr(A_ENV, 32'h0000_0008);
    rd(A_ENV, 32'h0000_0000);
    wr(A_PORT, 32'h0000_000f);
    for (int l = 0; l < 2; l++)
    begin
      wr(A_FREQ, 32'(l * 8));
      wr(A_ENV, 32'h0000_0008);
      rd(A_ENV, 32'h0000_0008);
      repeat (8000 * (l + 1)) @(posedge pclk);
      rd(A_ENV, 32'h0000_0008);
      check("burst period", 32'h0000_0040, {16'h0, per});
      check("burst high", 32'h0000_0020, {16'h0, hi});
      repeat (1400 * (l + 1)) @(posedge pclk);
      rd(A_ENV, 32'h0000_0000);
      check("burst off", 32'h0000_0000, {30'h0, tone, tone_n});
    end
    repeat (4) @(posedge pclk);
    summarize();
  end
endmodule
`default_nettype wire
